/* hdl/oag_core.sv */
`timescale 1ns/10ps
`default_nettype none
module oag_core
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic start,
   input wire logic [15:0] instr,
   input wire logic two_op,
   output logic busy,
   output logic mem_rd,
   output logic [15:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic res_valid,
   output logic res_src,
   output logic res_is_reg,
   output logic res_is_imm,
   output logic [2:0] res_reg,
   output logic [15:0] res_ea,
   output logic [15:0] res_imm,
   input wire logic wb_en,
   input wire logic [2:0] wb_reg,
   input wire logic [15:0] wb_data,
   input wire logic [2:0] rd_sel,
   output logic [15:0] rd_data
);
   oag_state_t state_q;
   logic [15:0] regs_q [OAG_NREG];
   logic [15:0] instr_q;
   logic phase_src_q;
   logic byte_op;
   logic [5:0] spec;
   logic [2:0] mode, rsel;
   logic [15:0] step, rval, ext_addr;
   logic need_ext, need_ind;

   assign byte_op = instr_q[OAG_BYTE_BIT];
   assign spec = phase_src_q ? instr_q[OAG_SRC_LSB +: 6]
      : instr_q[OAG_REG_LSB +: 6];
   assign rsel = spec[2:0];
   assign mode = spec[5:3];
   assign rval = regs_q[rsel];
   assign busy = (state_q != OAG_IDLE);

   // Step size: deferred modes, stack pointer and counter always two
   always_comb begin
      if (byte_op && !mode[0] && rsel != OAG_SP && rsel != OAG_PC) begin
         step = OAG_STEP_BYTE;
      end else begin
         step = OAG_STEP_WORD;
      end
   end

   assign need_ext = (mode == OAG_M_IDX) || (mode == OAG_M_IDXD) ||
      ((mode == OAG_M_AINC || mode == OAG_M_AINCD) && rsel == OAG_PC);
   assign need_ind = mode[0] && mode != OAG_M_DEF;
   assign ext_addr = regs_q[OAG_PC];

   assign rd_data = regs_q[rd_sel];

   // Operand sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= OAG_IDLE;
         instr_q <= 16'h0000;
         phase_src_q <= 1'b0;
         mem_rd <= 1'b0;
         mem_addr <= 16'h0000;
         res_valid <= 1'b0;
         res_src <= 1'b0;
         res_is_reg <= 1'b0;
         res_is_imm <= 1'b0;
         res_reg <= 3'h0;
         res_ea <= 16'h0000;
         res_imm <= 16'h0000;
      end else if (ce) begin
         res_valid <= 1'b0;
         case (state_q)
            OAG_IDLE: begin
               if (start) begin
                  instr_q <= instr;
                  phase_src_q <= two_op;
                  state_q <= OAG_DONE;
               end
            end
            OAG_DONE: begin
               res_src <= phase_src_q;
               res_reg <= rsel;
               res_is_reg <= 1'b0;
               res_is_imm <= 1'b0;
               case (mode)
                  OAG_M_REG: begin
                     res_is_reg <= 1'b1;
                     res_valid <= 1'b1;
                  end
                  OAG_M_DEF: begin
                     res_ea <= rval;
                     res_valid <= 1'b1;
                  end
                  OAG_M_AINC: begin
                     if (rsel == OAG_PC) begin
                        mem_rd <= 1'b1;
                        mem_addr <= ext_addr;
                        state_q <= OAG_EXT;
                     end else begin
                        res_ea <= rval;
                        res_valid <= 1'b1;
                     end
                  end
                  OAG_M_AINCD: begin
                     mem_rd <= 1'b1;
                     mem_addr <= rval;
                     state_q <= (rsel == OAG_PC) ? OAG_EXT : OAG_IND;
                  end
                  OAG_M_ADEC: begin
                     res_ea <= rval - step;
                     res_valid <= 1'b1;
                  end
                  OAG_M_ADECD: begin
                     mem_rd <= 1'b1;
                     mem_addr <= rval - step;
                     state_q <= OAG_IND;
                  end
                  default: begin
                     mem_rd <= 1'b1;
                     mem_addr <= ext_addr;
                     state_q <= OAG_EXT;
                  end
               endcase
               if ((!need_ext && !mode[0]) || mode == OAG_M_DEF ||
                  mode == OAG_M_ADEC ||
                  (mode == OAG_M_AINC && rsel != OAG_PC)) begin
                  if (phase_src_q) begin
                     phase_src_q <= 1'b0;
                  end else begin
                     state_q <= OAG_IDLE;
                  end
               end
            end
            OAG_EXT: begin
               if (mem_ack) begin
                  mem_rd <= 1'b0;
                  if (mode == OAG_M_AINC) begin
                     res_is_imm <= 1'b1;
                     res_imm <= mem_rdata;
                     res_ea <= mem_addr;
                     res_valid <= 1'b1;
                  end else if (mode == OAG_M_AINCD) begin
                     res_ea <= mem_rdata;
                     res_valid <= 1'b1;
                  end else if (mode == OAG_M_IDX) begin
                     // Counter advances past the index word only on this edge, so add two to mem_addr
                     res_ea <= mem_rdata + (rsel == OAG_PC ?
                        mem_addr + OAG_STEP_WORD : rval);
                     res_valid <= 1'b1;
                  end else begin
                     mem_rd <= 1'b1;
                     mem_addr <= mem_rdata + (rsel == OAG_PC ?
                        mem_addr + OAG_STEP_WORD : rval);
                  end
                  if (mode == OAG_M_IDXD) begin
                     state_q <= OAG_IND;
                  end else if (phase_src_q) begin
                     phase_src_q <= 1'b0;
                     state_q <= OAG_DONE;
                  end else begin
                     state_q <= OAG_IDLE;
                  end
               end
            end
            OAG_IND: begin
               if (mem_ack) begin
                  mem_rd <= 1'b0;
                  res_ea <= mem_rdata;
                  res_valid <= 1'b1;
                  if (phase_src_q) begin
                     phase_src_q <= 1'b0;
                     state_q <= OAG_DONE;
                  end else begin
                     state_q <= OAG_IDLE;
                  end
               end
            end
            default: state_q <= OAG_IDLE;
         endcase
      end
   end

   // Register file with pointer side effects and write-back
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < OAG_NREG; i++) begin
            regs_q[i] <= OAG_REG_RST;
         end
      end else if (ce) begin
         if (state_q == OAG_DONE) begin
            if ((mode == OAG_M_AINC && rsel != OAG_PC) ||
               (mode == OAG_M_AINCD && rsel != OAG_PC)) begin
               regs_q[rsel] <= rval + step;
            end else if (mode == OAG_M_ADEC || mode == OAG_M_ADECD) begin
               regs_q[rsel] <= rval - step;
            end
         end else if ((state_q == OAG_EXT) && mem_ack) begin
            regs_q[OAG_PC] <= regs_q[OAG_PC] + OAG_STEP_WORD;
         end else if (wb_en) begin
            if (byte_op && wb_reg != OAG_PC) begin
               regs_q[wb_reg][7:0] <= wb_data[7:0];
            end else begin
               regs_q[wb_reg] <= wb_data;
            end
         end
      end
   end
endmodule // oag_core
`default_nettype wire

/* hdl/oag_pkg.sv */
`default_nettype none
package oag_pkg;
   localparam int OAG_W = 16;
   localparam int OAG_NREG = 8;
   localparam logic [2:0] OAG_SP = 3'h6;
   localparam logic [2:0] OAG_PC = 3'h7;
   localparam int OAG_REG_LSB = 0;
   localparam int OAG_MODE_LSB = 3;
   localparam int OAG_SRC_LSB = 6;
   localparam int OAG_BYTE_BIT = 15;
   localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;
   localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
   localparam logic [15:0] OAG_REG_RST = 16'h0000;
   localparam logic [2:0] OAG_M_REG = 3'h0;
   localparam logic [2:0] OAG_M_DEF = 3'h1;
   localparam logic [2:0] OAG_M_AINC = 3'h2;
   localparam logic [2:0] OAG_M_AINCD = 3'h3;
   localparam logic [2:0] OAG_M_ADEC = 3'h4;
   localparam logic [2:0] OAG_M_ADECD = 3'h5;
   localparam logic [2:0] OAG_M_IDX = 3'h6;
   localparam logic [2:0] OAG_M_IDXD = 3'h7;
   typedef enum logic [2:0] {
      OAG_IDLE, OAG_EXT, OAG_IND, OAG_DONE
   } oag_state_t;
endpackage
`default_nettype wire

/* tb/oag_core_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module oag_core_asserts
   import oag_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic [15:0] instr,
   input wire logic two_op,
   input wire logic busy,
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   input wire logic mem_ack,
   input wire logic res_valid,
   input wire logic res_src,
   input wire logic res_is_reg,
   input wire logic [2:0] res_reg,
   input wire logic [15:0] res_ea,
   input wire logic wb_en,
   input wire logic [2:0] wb_reg,
   input wire logic [15:0] wb_data,
   input wire logic [2:0] rd_sel,
   input wire logic [15:0] rd_data
);
   logic byte_q;
   logic pend_q;
   wire logic go = start && !busy && !two_op;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Width of the last taken instruction and pending source result
   always_ff @(posedge clk) begin
      if (srst) begin
         byte_q <= 1'b0;
         pend_q <= 1'b0;
      end else if (start && !busy) begin
         byte_q <= instr[15];
         pend_q <= two_op;
      end else if (res_valid) begin
         pend_q <= 1'b0;
      end
   end
   chk_reg_latency: assert property (
      go && instr[5:3] == OAG_M_REG |-> ##2 res_valid && res_is_reg)
      else $error("register operand not reported");
   chk_reg_select: assert property (
      go && instr[5:3] == OAG_M_REG |-> ##2 res_reg == $past(instr[2:0], 2))
      else $error("wrong register number");
   chk_reg_no_access: assert property (
      go && instr[5:3] == OAG_M_REG |-> !mem_rd [*3])
      else $error("memory read in register mode");
   chk_read_hold: assert property (
      mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
      else $error("read request dropped early");
   chk_wb_byte_lane: assert property (
      !busy && wb_en && wb_reg == rd_sel |=> rd_sel != $past(rd_sel) ||
      rd_data == ((byte_q && $past(wb_reg) != OAG_PC) ?
      {$past(rd_data[15:8]), $past(wb_data[7:0])} : $past(wb_data)))
      else $error("write-back lane wrong");
   chk_src_first: assert property (
      res_valid |-> res_src == pend_q)
      else $error("operand order wrong");
   chk_defer_addr: assert property (
      go && instr[5:3] == OAG_M_DEF && rd_sel == instr[2:0] |->
      ##2 res_valid && res_ea == $past(rd_data, 2))
      else $error("deferred address wrong");
   chk_index_fetch: assert property (
      go && instr[5:3] == OAG_M_IDX && rd_sel == OAG_PC |->
      ##2 mem_rd && mem_addr == $past(rd_data, 2))
      else $error("index word not fetched at counter");
endmodule // oag_core_asserts
bind oag_core oag_core_asserts i_oag_core_asserts (.*);
`default_nettype wire

/* tb/oag_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module oag_core_bench;
   import oag_pkg::*;
   logic clk = 0, srst = 1, ce = 1, start = 0, two_op = 0, mem_ack = 0;
   logic wb_en = 0, bq = 0, busy, mem_rd, res_valid, res_src;
   logic res_is_reg, res_is_imm;
   logic [15:0] instr = 0, wb_data = 0, mem_rdata, mem_addr, res_ea;
   logic [15:0] res_imm, rd_data, w, rg [8];
   logic [2:0] wb_reg = 0, rd_sel = 0, res_reg;
   logic [21:0] expq [$];
   logic [31:0] seed = 32'h00000061;
   int num_errors = 0, comparisons = 0, cyc = 0;
   oag_core i_oag_core (.*);
   always #4 clk = ~clk;
   assign mem_rdata = mf(mem_addr);
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   function automatic logic [15:0] mf(logic [15:0] a);
      return {a[7:0], a[15:8]} ^ 16'h3C5A;
   endfunction
   // Keeps the counter out of the decrement modes
   function automatic logic [5:0] fx(logic [5:0] a);
      return (a[5:4] == 2'h2 && a[2:0] == OAG_PC) ? {a[5:3], OAG_SP} : a;
   endfunction
   task automatic check(input string n, input logic [21:0] s, e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] r, input logic [15:0] d);
      wb_en = 1;
      wb_reg = r;
      wb_data = d;
      rd_sel = r;
      rg[r] = (bq && r != OAG_PC) ? {rg[r][15:8], d[7:0]} : d;
      @(negedge clk);
      // Select held one more cycle so the written lane can be seen
      wb_en = 0;
      @(negedge clk);
   endtask
   task automatic opnd(input logic [2:0] m, r, input logic s);
      logic [15:0] st, v;
      st = (bq && r < OAG_SP) ? OAG_STEP_BYTE : OAG_STEP_WORD;
      v = rg[r];
      case (m)
         OAG_M_AINC: begin
            v = r == OAG_PC ? mf(v) : v;
            rg[r] += st;
         end
         OAG_M_AINCD: begin
            v = mf(v);
            rg[r] += OAG_STEP_WORD;
         end
         OAG_M_ADEC: begin
            rg[r] -= st;
            v = rg[r];
         end
         OAG_M_ADECD: begin
            rg[r] -= OAG_STEP_WORD;
            v = mf(rg[r]);
         end
         OAG_M_IDX, OAG_M_IDXD: begin
            v = mf(rg[OAG_PC]);
            rg[OAG_PC] += OAG_STEP_WORD;
            v = v + rg[r];
            if (m[0]) v = mf(v);
         end
         default: ;
      endcase
      if (m == OAG_M_REG) v = 16'h0000;
      expq.push_back({s, m == OAG_M_REG, m == OAG_M_AINC && r == OAG_PC, r, v});
   endtask
   always @(negedge clk) begin
      cyc++;
      mem_ack <= mem_rd === 1'b1 && !mem_ack && cyc[1];
      if (res_valid === 1'b1) begin
         if (expq.size() == 0) check("extra", 22'h000001, 22'h000000);
         else check("operand", {res_src, res_is_reg, res_is_imm,
            res_reg, res_is_imm ? res_imm : res_is_reg ? 16'h0000 : res_ea},
            expq.pop_front());
      end
      if (cyc > 20000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      logic [15:0] x;
      repeat (16) @(negedge clk);
      srst = 0;
      for (int i = 0; i < 8; i++) wr(3'(i), rnd());
      for (int i = 0; i < 320; i++) begin
         w = rnd();
         w[5:0] = fx({3'(i), w[2:0]});
         w[11:6] = fx(w[11:6]);
         two_op = w[12];
         bq = w[15];
         if (two_op) opnd(w[11:9], w[8:6], 1'b1);
         opnd(w[5:3], w[2:0], 1'b0);
         instr = w;
         start = 1;
         rd_sel = w[5:3] == OAG_M_IDX ? OAG_PC : w[2:0];
         @(negedge clk);
         start = 0;
         while (busy !== 1'b0) @(negedge clk);
         @(negedge clk);
         for (int r = 0; r < 8; r++) begin
            rd_sel = 3'(r);
            #2;
            check("register", 22'(rd_data), 22'(rg[r]));
            @(negedge clk);
         end
         @(negedge clk);
         x = rnd();
         if (x[0]) wr(x[3:1], rnd());
      end
      check("pending", 22'(expq.size()), 22'h000000);
      final_report();
   end
endmodule // oag_core_bench
`default_nettype wire
